// [tb/csfl_flags_monitor.sv]
// Purpose: port checker for the status flag logic
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module csfl_flags_monitor (
  input wire clk,
  input wire rst,
  input wire aluValid,
  input wire aluCarryOut,
  input wire shiftValid,
  input wire xferValid,
  input wire [7:0] xferData,
  input wire [3:0] flagOp,
  input wire swBreakReq,
  input wire hwIrqAccept,
  input wire swBreakAccept,
  input wire [7:0] stackedStatus,
  input wire stackedValid,
  input wire [1:0] branchSel,
  input wire branchSense,
  input wire branchTaken,
  input wire [7:0] status
);
  logic [7:0] xdQ;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Registered copy keeps the past sample of the whole transfer byte simple
  always @(posedge clk) xdQ <= xferData;
  property p_resetI; $fell(rst) |-> status[2]; endproperty
  a_resetI: assert property (p_resetI) else $error("mask flag low after reset");
  property p_brk; status[4] == 1'b0; endproperty
  a_brk: assert property (p_brk) else $error("live break bit set");
  property p_swAcc; swBreakReq |-> swBreakAccept && !hwIrqAccept; endproperty
  a_swAcc: assert property (p_swAcc) else $error("break not taken");
  property p_mask; status[2] |-> !hwIrqAccept; endproperty
  a_mask: assert property (p_mask) else $error("masked request taken");
  property p_entry; hwIrqAccept || swBreakAccept |=> status[2] && stackedValid; endproperty
  a_entry: assert property (p_entry) else $error("entry did not mask");
  property p_swStack; swBreakAccept |=> stackedStatus == ($past(status) | 8'h10); endproperty
  a_swStack: assert property (p_swStack) else $error("break push wrong");
  property p_hwStack; hwIrqAccept |=> stackedStatus == $past(status); endproperty
  a_hwStack: assert property (p_hwStack) else $error("hardware push wrong");
  property p_xfer;
    xferValid && !aluValid && !shiftValid |=> status[1] == (xdQ == 8'h00) && status[7] == xdQ[7];
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer flags wrong");
  property p_carry; aluValid && flagOp != 4'h1 && flagOp != 4'h2 |=> status[0] == $past(aluCarryOut);
  endproperty
  a_carry: assert property (p_carry) else $error("carry not loaded");
  property p_branch;
    branchTaken == ((branchSel[1] ? status[6 + branchSel[0]] : status[branchSel[0]]) == branchSense);
  endproperty
  a_branch: assert property (p_branch) else $error("branch test wrong");
endmodule
`default_nettype wire

// [tb/csfl_testbench.sv]
// Purpose: self-checking bench for the status flag logic
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes: status is read back over the register port after every event
`include "csfl_flags_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, aluValid = 1'b0, aluIsSub = 1'b0;
  logic aluIsAddSub = 1'b0, aluCarryOut = 1'b0, shiftValid = 1'b0, shiftCarryOut = 1'b0;
  logic xferValid = 1'b0, bitTestValid = 1'b0, hwIrqReq = 1'b0, swBreakReq = 1'b0;
  logic branchSense = 1'b0, rdSeen = 1'b0;
  logic [1:0] regAddr = 2'h0, branchSel = 2'h0;
  logic [3:0] flagOp = 4'h0;
  logic [7:0] regWrData = 8'h00, aluOpA = 8'h00, aluOpB = 8'h00, aluResult = 8'h00;
  logic [7:0] shiftResult = 8'h00, xferData = 8'h00, bitTestMem = 8'h00, bitTestAcc = 8'h81;
  logic [7:0] model = 8'h04, stk, pre, q[$];
  wire [7:0] regRdData, stackedStatus, status;
  wire hwIrqAccept, swBreakAccept, stackedValid, branchTaken, decimalMode, decimalAdjustEn;
  wire memToMemMode, destFromIndexX, resultToAcc;
  int miscompares = 0, cmp_count = 0;
  int pos[10] = '{0, 0, 0, 2, 2, 3, 3, 5, 5, 6};
  int kinds[5] = '{0, 1, 2, 6, 7};
  always #2.5 clk = ~clk;
  csfl_status_flags csfl_status_flags_i (.*);
  task close_out;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rdSeen) chk(regRdData, q.pop_front());
    rdSeen <= regRd;
  end
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    q.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  // Mode steering follows D and T; add/sub marker toggled so both adjust levels show
  task modes;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      aluIsAddSub <= m[0];
      @(negedge clk);
      chk({3'h0, decimalMode, decimalAdjustEn, memToMemMode, destFromIndexX, resultToAcc},
          {3'h0, model[3], model[3] & m[0], model[5], model[5], ~model[5]});
    end
    @(posedge clk);
    aluIsAddSub <= 1'b0;
  endtask
  // Kinds: 0 move, 1 shift, 2 bit test, 3 flag op, 4 break, 5 write, 6 add, 7 sub
  task ev(input int k, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [7:0] bb, r;
    bb = (k == 7) ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, k == 7};
    r = (k > 5) ? s[7:0] : a;
    @(posedge clk);
    {xferData, shiftResult, bitTestMem, aluOpA, regWrData} <= {5{a}};
    {aluOpB, aluResult, aluCarryOut, shiftCarryOut} <= {b, s[7:0], s[8], b[0]};
    {xferValid, shiftValid, bitTestValid} <= {k == 0, k == 1, k == 2};
    {swBreakReq, regWr, aluValid, aluIsSub} <= {k == 4, k == 5, k > 5, k == 7};
    flagOp <= (k == 3) ? a[3:0] : 4'h0;
    regAddr <= 2'h0;
    @(posedge clk);
    {xferValid, shiftValid, bitTestValid, swBreakReq, regWr, aluValid} <= 6'h00;
    flagOp <= 4'h0;
    if (k < 2 || k > 5) model[1] = r == 8'h00;
    if (k < 2 || k > 5) model[7] = r[7];
    if (k == 1) model[0] = b[0];
    if (k > 5) model[0] = s[8];
    if (k > 5) model[6] = a[7] == bb[7] && r[7] != a[7];
    if (k == 2) model[7:6] = a[7:6];
    if (k == 2) model[1] = (a & 8'h81) == 8'h00;
    if (k == 3 && a > 0 && a < 10) model[pos[a]] = a[0] && a != 8'h09;
    if (k == 4) stk = model | 8'h10;
    if (k == 4) model[2] = 1'b1;
    if (k == 5) model = a & 8'hef;
    rd(2'h0, model);
    if (k == 4) rd(2'h1, stk);
  endtask
  initial begin
    void'($urandom(32'h798f));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, 8'h04);
    ev(5, 8'hff, 8'h00);
    modes;
    rd(2'h3, 8'h00);
    for (int k = 0; k < 11; k++) ev(3, k, 8'h00);
    modes;
    for (int n = 0; n < 60; n++) ev(kinds[$urandom_range(4, 0)], $urandom, $urandom);
    pre = model;
    @(posedge clk);
    hwIrqReq <= 1'b1;
    @(posedge clk);
    model[2] = 1'b1;
    @(negedge clk);
    chk({7'h00, hwIrqAccept}, 8'h00);
    rd(2'h1, pre);
    ev(4, 8'h00, 8'h00);
    hwIrqReq <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      {branchSense, branchSel} <= s[2:0];
      @(negedge clk);
      chk({7'h00, branchTaken}, {7'h00, (s[1] ? model[6 + s[0]] : model[s[0]]) == s[2]});
    end
    repeat (2) @(posedge clk);
    close_out;
  end
endmodule
bind csfl_status_flags csfl_flags_monitor csfl_flags_monitor_i (.*);
`default_nettype wire

// [verilog/csfl_flags_defs.vh]
// Purpose: constants for the processor status flag logic
// Assumes: 8-bit status byte, plain register port with 2-bit address
// Notes: bit positions follow the status byte layout
`ifndef CSFL_FLAGS_DEFS_VH
`define CSFL_FLAGS_DEFS_VH

// Register indices on the plain register port
`define CSFL_REG_STATUS 2'h0
`define CSFL_REG_STACKED 2'h1
`define CSFL_REG_BRANCH 2'h2

// Flag positions inside the status byte
`define CSFL_BIT_C 0
`define CSFL_BIT_Z 1
`define CSFL_BIT_I 2
`define CSFL_BIT_D 3
`define CSFL_BIT_B 4
`define CSFL_BIT_T 5
`define CSFL_BIT_V 6
`define CSFL_BIT_N 7

// Reset value: only interrupt-disable is defined, the rest chosen as 0
`define CSFL_STATUS_RESET 8'h04

// Sign bit and bit-test source bits
`define CSFL_SIGN_BIT 7
`define CSFL_TEST_V_BIT 6
`define CSFL_TEST_N_BIT 7

// Branch condition select codes
`define CSFL_BR_CARRY 2'h0
`define CSFL_BR_ZERO 2'h1
`define CSFL_BR_OVERFLOW 2'h2
`define CSFL_BR_NEGATIVE 2'h3

// Dedicated flag instruction codes
`define CSFL_OP_NONE 4'h0
`define CSFL_OP_CARRY_RAISE 4'h1
`define CSFL_OP_CARRY_LOWER 4'h2
`define CSFL_OP_IRQ_MASK_RAISE 4'h3
`define CSFL_OP_IRQ_MASK_LOWER 4'h4
`define CSFL_OP_DECIMAL_RAISE 4'h5
`define CSFL_OP_DECIMAL_LOWER 4'h6
`define CSFL_OP_INDEX_MODE_RAISE 4'h7
`define CSFL_OP_INDEX_MODE_LOWER 4'h8
`define CSFL_OP_OVERFLOW_LOWER 4'h9

`endif

// [verilog/csfl_status_flags.v]
// Purpose: processor status flag logic of an 8-bit core
// Assumes: core events are one-cycle pulses on clk; one event class per cycle
// Notes: register port reads return data one cycle after the read strobe
//
// Contract
// - Status is one 8-bit register of individual condition and mode flags.
// - Reset forces interrupt-disable to 1; other flags get no defined value.
// - Branches can test carry, zero, overflow or negative.
// - In decimal mode zero, overflow and negative need not be meaningful.
// - Carry takes ALU carry or borrow, and shift or rotate carry.
// - Zero sets on a zero arithmetic or transfer result, else clears.
// - Interrupt-disable masks all sources except the software break.
// - Accepting any interrupt sets interrupt-disable.
// - Decimal flag 0 selects binary, 1 selects decimal arithmetic.
// - Decimal mode applies only to add and subtract with carry, auto-corrected.
// - Break bit of the live status always reads 0.
// - Software break pushes status with break bit forced to 1.
// - Index mode 0: accumulator with memory, result to accumulator.
// - Index mode 1: operations run memory to memory, bypassing accumulator.
// - Memory mode: X addresses destination and first operand, result there.
// - Overflow sets when signed byte add or subtract leaves -128..+127.
// - Bit test copies memory bit 6 into overflow.
// - Bit test copies memory bit 7 into negative.
// - Negative follows bit 7 of arithmetic or transfer result.
// - Dedicated set/clear for C, I, D, T and clear for V only.
`include "csfl_flags_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module csfl_status_flags (
  input wire clk,
  input wire rst,
  // Register port
  input wire [1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  // ALU add or subtract result
  input wire aluValid,
  input wire aluIsSub,
  input wire aluIsAddSub,
  input wire [7:0] aluOpA,
  input wire [7:0] aluOpB,
  input wire [7:0] aluResult,
  input wire aluCarryOut,
  // Shift and rotate
  input wire shiftValid,
  input wire [7:0] shiftResult,
  input wire shiftCarryOut,
  // Data transfer
  input wire xferValid,
  input wire [7:0] xferData,
  // Memory bit test
  input wire bitTestValid,
  input wire [7:0] bitTestMem,
  input wire [7:0] bitTestAcc,
  // Dedicated flag instructions
  input wire [3:0] flagOp,
  // Interrupt entry
  input wire hwIrqReq,
  input wire swBreakReq,
  output wire hwIrqAccept,
  output wire swBreakAccept,
  output reg [7:0] stackedStatus,
  output reg stackedValid,
  // Branch test
  input wire [1:0] branchSel,
  input wire branchSense,
  output wire branchTaken,
  // Arithmetic mode steering
  output wire decimalMode,
  output wire decimalAdjustEn,
  output wire memToMemMode,
  output wire destFromIndexX,
  output wire resultToAcc,
  output wire [7:0] status
);

  reg flagC;
  reg flagZ;
  reg flagI;
  reg flagD;
  reg flagT;
  reg flagV;
  reg flagN;
  reg next_flagC;
  reg next_flagZ;
  reg next_flagI;
  reg next_flagD;
  reg next_flagT;
  reg next_flagV;
  reg next_flagN;
  reg branchFlag;
  wire [7:0] liveStatus;
  wire [7:0] aluOpBEff;
  wire aluOverflow;
  wire anyAccept;

  // Break bit is never held in the live byte, so it reads 0
  assign liveStatus = {flagN, flagV, flagT, 1'b0, flagD, flagI, flagZ, flagC};
  assign status = liveStatus;

  // Software break ignores the mask; hardware sources wait for I to be 0
  assign swBreakAccept = swBreakReq;
  assign hwIrqAccept = hwIrqReq & ~flagI & ~swBreakReq;
  assign anyAccept = swBreakAccept | hwIrqAccept;

  // Subtract is add of the inverted operand, so one sign test covers both
  assign aluOpBEff = aluIsSub ? ~aluOpB : aluOpB;
  assign aluOverflow = (aluOpA[`CSFL_SIGN_BIT] == aluOpBEff[`CSFL_SIGN_BIT]) &
                       (aluResult[`CSFL_SIGN_BIT] != aluOpA[`CSFL_SIGN_BIT]);

  // Mode steering for the datapath
  assign decimalMode = flagD;
  assign decimalAdjustEn = flagD & aluIsAddSub;
  assign memToMemMode = flagT;
  assign destFromIndexX = flagT;
  assign resultToAcc = ~flagT;

  always @* begin
    case (branchSel)
      `CSFL_BR_CARRY: branchFlag = flagC;
      `CSFL_BR_ZERO: branchFlag = flagZ;
      `CSFL_BR_OVERFLOW: branchFlag = flagV;
      `CSFL_BR_NEGATIVE: branchFlag = flagN;
      default: branchFlag = 1'b0;
    endcase
  end
  assign branchTaken = (branchFlag == branchSense);

  always @* begin
    next_flagC = flagC;
    next_flagZ = flagZ;
    next_flagI = flagI;
    next_flagD = flagD;
    next_flagT = flagT;
    next_flagV = flagV;
    next_flagN = flagN;
    // Software write first, so any core event in the same cycle wins
    if (regWr && regAddr == `CSFL_REG_STATUS) begin
      next_flagC = regWrData[`CSFL_BIT_C];
      next_flagZ = regWrData[`CSFL_BIT_Z];
      next_flagI = regWrData[`CSFL_BIT_I];
      next_flagD = regWrData[`CSFL_BIT_D];
      next_flagT = regWrData[`CSFL_BIT_T];
      next_flagV = regWrData[`CSFL_BIT_V];
      next_flagN = regWrData[`CSFL_BIT_N];
    end
    // Decimal results still update Z, V, N; their values carry no meaning
    if (aluValid) begin
      next_flagC = aluCarryOut;
      next_flagZ = (aluResult == 8'h00);
      next_flagV = aluOverflow;
      next_flagN = aluResult[`CSFL_SIGN_BIT];
    end else if (shiftValid) begin
      next_flagC = shiftCarryOut;
      next_flagZ = (shiftResult == 8'h00);
      next_flagN = shiftResult[`CSFL_SIGN_BIT];
    end else if (xferValid) begin
      next_flagZ = (xferData == 8'h00);
      next_flagN = xferData[`CSFL_SIGN_BIT];
    end else if (bitTestValid) begin
      next_flagZ = ((bitTestAcc & bitTestMem) == 8'h00);
      next_flagV = bitTestMem[`CSFL_TEST_V_BIT];
      next_flagN = bitTestMem[`CSFL_TEST_N_BIT];
    end
    // No op touches Z, B or N, and none raises V
    case (flagOp)
      `CSFL_OP_CARRY_RAISE: next_flagC = 1'b1;
      `CSFL_OP_CARRY_LOWER: next_flagC = 1'b0;
      `CSFL_OP_IRQ_MASK_RAISE: next_flagI = 1'b1;
      `CSFL_OP_IRQ_MASK_LOWER: next_flagI = 1'b0;
      `CSFL_OP_DECIMAL_RAISE: next_flagD = 1'b1;
      `CSFL_OP_DECIMAL_LOWER: next_flagD = 1'b0;
      `CSFL_OP_INDEX_MODE_RAISE: next_flagT = 1'b1;
      `CSFL_OP_INDEX_MODE_LOWER: next_flagT = 1'b0;
      `CSFL_OP_OVERFLOW_LOWER: next_flagV = 1'b0;
      default: next_flagV = next_flagV;
    endcase
    // Interrupt entry sets I last so a same-cycle clear cannot lose it
    if (anyAccept) begin
      next_flagI = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      flagC <= 1'b0;
      flagZ <= 1'b0;
      flagI <= 1'b1;
      flagD <= 1'b0;
      flagT <= 1'b0;
      flagV <= 1'b0;
      flagN <= 1'b0;
    end else begin
      flagC <= next_flagC;
      flagZ <= next_flagZ;
      flagI <= next_flagI;
      flagD <= next_flagD;
      flagT <= next_flagT;
      flagV <= next_flagV;
      flagN <= next_flagN;
    end
  end

  // Pushed byte is the status before entry, with B telling the source apart
  always @(posedge clk) begin
    if (rst) begin
      stackedStatus <= 8'h00;
      stackedValid <= 1'b0;
    end else begin
      stackedValid <= anyAccept;
      if (swBreakAccept) begin
        stackedStatus <= liveStatus | (8'h01 << `CSFL_BIT_B);
      end else if (hwIrqAccept) begin
        stackedStatus <= liveStatus;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `CSFL_REG_STATUS: regRdData <= liveStatus;
        `CSFL_REG_STACKED: regRdData <= stackedStatus;
        `CSFL_REG_BRANCH: regRdData <= {7'h00, branchTaken};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

`default_nettype wire
